// ==== verilog/aofc_pkg.sv ====
// constants and types for the output format control block
package aofc_pkg;
  // register offsets (index on the register port)
  localparam logic [9:0] ADDR_CHAN_INDEX = 10'h005;
  localparam logic [9:0] ADDR_CLK_DIV = 10'h00B;
  localparam logic [9:0] ADDR_LINE_FMT = 10'h014;
  localparam logic [9:0] ADDR_DRV_TERM = 10'h015;
  localparam logic [9:0] ADDR_CLK_PHASE = 10'h016;
  localparam logic [9:0] ADDR_STREAM_FMT = 10'h021;
  localparam logic [9:0] ADDR_TRANSFER = 10'h0FF;
  localparam logic [9:0] ADDR_SPEED_LIMIT = 10'h100;
  localparam logic [9:0] ADDR_USER_IO_B = 10'h101;
  // reset values
  localparam logic [7:0] RST_LINE_FMT = 8'h01;
  localparam logic [7:0] RST_DRV_TERM = 8'h00;
  localparam logic [7:0] RST_CLK_PHASE = 8'h03;
  localparam logic [7:0] RST_STREAM_FMT = 8'h32;
  localparam logic [7:0] RST_SPEED_LIMIT = 8'h00;
  localparam logic [7:0] RST_USER_IO_B = 8'h00;
  localparam logic [7:0] RST_CHAN_INDEX = 8'h3F;
  localparam logic [7:0] RST_CLK_DIV = 8'h00;
  // writable-bit masks, open bits read zero
  localparam logic [7:0] MASK_LINE_FMT = 8'h45;
  localparam logic [7:0] MASK_DRV_TERM = 8'h31;
  localparam logic [7:0] MASK_CLK_PHASE = 8'h7F;
  localparam logic [7:0] MASK_STREAM_FMT = 8'hF7;
  localparam logic [7:0] MASK_SPEED_LIMIT = 8'h77;
  localparam logic [7:0] MASK_USER_IO_B = 8'h01;
  localparam logic [7:0] MASK_CHAN_INDEX = 8'h3F;
  localparam logic [7:0] MASK_CLK_DIV = 8'h07;
  // field positions
  localparam int LF_REDUCED_BIT = 6;
  localparam int LF_INVERT_BIT = 2;
  localparam int LF_TWOS_BIT = 0;
  localparam int DT_TERM_LSB = 4;
  localparam int DT_DRIVE2X_BIT = 0;
  localparam int CP_SAMPLE_LSB = 4;
  localparam int SF_LSB_FIRST_BIT = 7;
  localparam int SF_MODE_LSB = 4;
  localparam int SF_FRAME2X_BIT = 2;
  localparam int SF_BITS_LSB = 0;
  localparam int CI_FCO_BIT = 4;
  localparam int CI_DCO_BIT = 5;
  localparam int TR_LOAD_BIT = 0;
  localparam int UB_PULL_OFF_BIT = 0;
  localparam logic [1:0] SF_BITS_10 = 2'h3;
  localparam logic [2:0] SF_MODE_ONE_LANE = 3'h4;
  localparam logic [3:0] PHASE_STEP_DEG = 4'h6; // tens of degrees per code
  localparam int SAMPLE_W = 12;
  localparam int CHANNELS = 4;
  typedef enum logic [1:0] {AOFC_IDLE = 2'b00, AOFC_ACK = 2'b01} aofc_state_t;
endpackage

// ==== verilog/aofc_core.sv ====
// register file and output format logic of the serial output control block
module aofc_core
  import aofc_pkg::*;
(
  // clock and reset
  input wire logic clock, // 200 MHz clock
  input wire logic reset_n, // async reset, active low
  // register port
  input wire logic regWrite, // register write strobe
  input wire logic regRead, // register read strobe
  input wire logic [9:0] regAddr, // register offset
  input wire logic [7:0] regWdata, // write data
  output logic [7:0] regRdata, // read data
  output logic regAck, // access done pulse
  // sample input side
  input wire logic [SAMPLE_W-1:0] sampleData, // raw twos complement sample
  input wire logic [1:0] sampleChan, // channel of sample
  input wire logic sampleValid, // sample offered
  output logic sampleReady, // sample accepted
  // formatted output side
  output logic [SAMPLE_W-1:0] outData, // formatted sample, inverted when the invert bit is set
  output logic [1:0] outChan, // channel of formatted sample
  output logic outValid, // formatted sample offered
  input wire logic outReady, // serializer takes sample
  // level and driver controls
  output logic reducedLevel, // reduced-range differential level
  output logic [1:0] driverCurrent, // auto current code
  output logic [1:0] termSelect, // termination resistor code
  output logic frameClkDrive2x, // frame clock 2x drive
  output logic bitClkDrive2x, // bit clock 2x drive
  // sampling and bit clock phase
  output logic [2:0] samplePhaseCycles, // sampling delay in input cycles
  output logic [3:0] bitClkPhaseStep, // bit clock phase code
  output logic [9:0] bitClkPhaseDeg, // bit clock phase in degrees
  // stream format decode
  output logic [3:0] serialBitsPerSample, // 12 or 10
  output logic frame2x, // double frame mode
  output logic ddrMode, // double data rate
  output logic oneLane, // one-lane mode
  output logic byteWise, // bytewise order
  output logic lsbFirst, // lsb first
  output logic [3:0] bitClkMultHalf, // bit clock multiple of fs, in halves
  // override limits and pull-down
  output logic [1:0] limitResolution, // active resolution limit
  output logic [2:0] limitRate, // active rate limit code
  output logic limitEnable, // override active
  output logic sdioPullDownEn // pull-down connected
);
  typedef struct packed {
    // register port state
    aofc_state_t state;
    // programmed registers, open bits held at zero
    logic [7:0] lineFmt;
    logic [7:0] drvTerm;
    logic [7:0] clkPhase;
    logic [7:0] streamFmt;
    logic [7:0] speedStaged;
    logic [7:0] speedActive;
    logic [7:0] userIoB;
    logic [7:0] chanIndex;
    logic [7:0] clkDiv;
    logic [7:0] rdata;
    // two-entry output buffer
    logic [1:0][SAMPLE_W-1:0] bufData;
    logic [1:0][1:0] bufChan;
    logic [1:0] bufFull;
    logic bufHead;
    logic bufTail;
  } aofc_regs_t;

  aofc_regs_t state_reg;
  aofc_regs_t state_next;

  // masked register update, open bits never stored
  function automatic logic [7:0] maskWrite(input logic [7:0] data, input logic [7:0] mask);
    maskWrite = data & mask;
  endfunction

  // formats one sample: offset binary flip and stream inversion
  function automatic logic [SAMPLE_W-1:0] formatSample(input logic [SAMPLE_W-1:0] s, input logic [7:0] lf);
    logic [SAMPLE_W-1:0] v;
    v = s;
    if (!lf[LF_TWOS_BIT]) begin
      v[SAMPLE_W-1] = ~v[SAMPLE_W-1];
    end
    if (lf[LF_INVERT_BIT]) begin
      v = ~v;
    end
    formatSample = v;
  endfunction

  // read-back mux, open bits are already zero in storage
  function automatic logic [7:0] readBack(input logic [9:0] addr, input aofc_regs_t r);
    case (addr)
      ADDR_LINE_FMT: begin
        readBack = r.lineFmt;
      end
      ADDR_DRV_TERM: begin
        readBack = r.drvTerm;
      end
      ADDR_CLK_PHASE: begin
        readBack = r.clkPhase;
      end
      ADDR_STREAM_FMT: begin
        readBack = r.streamFmt;
      end
      ADDR_SPEED_LIMIT: begin
        readBack = r.speedStaged; // staged value, not the active one
      end
      ADDR_USER_IO_B: begin
        readBack = r.userIoB;
      end
      ADDR_CHAN_INDEX: begin
        readBack = r.chanIndex;
      end
      ADDR_CLK_DIV: begin
        readBack = r.clkDiv;
      end
      default: begin
        readBack = 8'h00; // unmapped and transfer read zero
      end
    endcase
  endfunction

  // driver current per signalling level, chosen by the block for the right swing
  function automatic logic [1:0] currentFor(input logic reduced);
    case (reduced)
      1'b1: begin
        currentFor = 2'h3; // reduced-range swing
      end
      default: begin
        currentFor = 2'h1; // standard-range swing
      end
    endcase
  endfunction

  // 2x drive for one picked clock output, dropped while a termination is set
  function automatic logic clockDrive2x(input logic [7:0] drv, input logic picked);
    logic termOn;
    termOn = (drv[DT_TERM_LSB +: 2] != 2'h0);
    clockDrive2x = drv[DT_DRIVE2X_BIT] & picked & ~termOn;
  endfunction

  // sampling delay in input clock cycles, zero while the divider is idle
  function automatic logic [2:0] sampleDelay(input logic [7:0] phase, input logic [7:0] div);
    if (div[2:0] != 3'h0) begin
      sampleDelay = phase[CP_SAMPLE_LSB +: 3];
    end else begin
      sampleDelay = 3'h0;
    end
  endfunction

  // bit clock phase in degrees; operands widened first so the product is not cut
  function automatic logic [9:0] phaseDegrees(input logic [3:0] step);
    logic [9:0] tens;
    tens = 10'(step) * 10'(PHASE_STEP_DEG);
    phaseDegrees = tens * 10'd10;
  endfunction

  // serial bits per sample from the two-bit size code
  function automatic logic [3:0] bitsFor(input logic [1:0] code);
    if (code == SF_BITS_10) begin
      bitsFor = 4'hA;
    end else begin
      bitsFor = 4'hC;
    end
  endfunction

  // lane mode decode into {ddr, one lane, bytewise}
  function automatic logic [2:0] laneDecode(input logic [2:0] mode);
    case (mode)
      3'h0: begin
        laneDecode = 3'b000; // sdr two-lane bitwise
      end
      3'h1: begin
        laneDecode = 3'b001; // sdr two-lane bytewise
      end
      3'h2: begin
        laneDecode = 3'b100; // ddr two-lane bitwise
      end
      3'h3: begin
        laneDecode = 3'b101; // ddr two-lane bytewise
      end
      SF_MODE_ONE_LANE: begin
        laneDecode = 3'b110; // ddr one lane
      end
      default: begin
        laneDecode = {mode[1], 1'b0, mode[0]}; // reserved codes
      end
    endcase
  endfunction

  // bit clock multiple of fs in halves: ddr over two lanes halves it
  function automatic logic [3:0] multFor(input logic [3:0] bits, input logic ddr, input logic one);
    if (ddr && !one) begin
      multFor = bits >> 1;
    end else begin
      multFor = bits;
    end
  endfunction

  // two-entry buffer handshake: ready while the tail entry is free
  logic bufWrite;
  logic bufRead;
  assign sampleReady = ~state_reg.bufFull[state_reg.bufTail];
  assign bufWrite = sampleValid & sampleReady;
  assign bufRead = outValid & outReady;

  // an access is taken only while no acknowledge is pending
  logic regTaken;
  assign regTaken = (state_reg.state == AOFC_IDLE) && (regWrite || regRead);

  // transfer strobe: a taken write of one to the load bit
  logic loadOverride;
  assign loadOverride = regTaken && regWrite && (regAddr == ADDR_TRANSFER) && regWdata[TR_LOAD_BIT];

  // next-state logic: register port and two-entry buffer
  always_comb begin
    state_next = state_reg;
    state_next.state = AOFC_IDLE;
    if (regTaken) begin
      state_next.state = AOFC_ACK;
      // write side: masked store, acting at once except the staged speed limit
      if (regWrite) begin
        case (regAddr)
          ADDR_LINE_FMT: begin
            state_next.lineFmt = maskWrite(regWdata, MASK_LINE_FMT);
          end
          ADDR_DRV_TERM: begin
            state_next.drvTerm = maskWrite(regWdata, MASK_DRV_TERM);
          end
          ADDR_CLK_PHASE: begin
            state_next.clkPhase = maskWrite(regWdata, MASK_CLK_PHASE);
          end
          ADDR_STREAM_FMT: begin
            state_next.streamFmt = maskWrite(regWdata, MASK_STREAM_FMT);
          end
          ADDR_SPEED_LIMIT: begin
            state_next.speedStaged = maskWrite(regWdata, MASK_SPEED_LIMIT);
          end
          ADDR_USER_IO_B: begin
            state_next.userIoB = maskWrite(regWdata, MASK_USER_IO_B);
          end
          ADDR_CHAN_INDEX: begin
            state_next.chanIndex = maskWrite(regWdata, MASK_CHAN_INDEX);
          end
          ADDR_CLK_DIV: begin
            state_next.clkDiv = maskWrite(regWdata, MASK_CLK_DIV);
          end
          ADDR_TRANSFER: begin
            if (loadOverride) begin
              state_next.speedActive = state_reg.speedStaged;
            end
          end
          default: begin
          end
        endcase
      end
      // read side: capture the addressed value for the answer cycle
      state_next.rdata = readBack(regAddr, state_reg);
    end
    // buffer fill at the tail, formatted with the line format of this cycle
    if (bufWrite) begin
      state_next.bufData[state_reg.bufTail] = formatSample(sampleData, state_reg.lineFmt);
      state_next.bufChan[state_reg.bufTail] = sampleChan;
      state_next.bufFull[state_reg.bufTail] = 1'b1;
      state_next.bufTail = ~state_reg.bufTail;
    end
    // buffer drain at the head
    if (bufRead) begin
      state_next.bufFull[state_reg.bufHead] = 1'b0;
      state_next.bufHead = ~state_reg.bufHead;
    end
  end

  // state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // all registers come up at their default codes
      state_reg <= '0;
      state_reg.state <= AOFC_IDLE;
      state_reg.lineFmt <= RST_LINE_FMT;
      state_reg.drvTerm <= RST_DRV_TERM;
      state_reg.clkPhase <= RST_CLK_PHASE;
      state_reg.streamFmt <= RST_STREAM_FMT;
      state_reg.speedStaged <= RST_SPEED_LIMIT;
      state_reg.speedActive <= RST_SPEED_LIMIT;
      state_reg.userIoB <= RST_USER_IO_B;
      state_reg.chanIndex <= RST_CHAN_INDEX;
      state_reg.clkDiv <= RST_CLK_DIV;
    end else begin
      state_reg <= state_next;
    end
  end

  // register port answer
  assign regAck = (state_reg.state == AOFC_ACK);
  assign regRdata = state_reg.rdata;

  // buffer output side
  assign outValid = state_reg.bufFull[state_reg.bufHead];
  assign outData = state_reg.bufData[state_reg.bufHead];
  assign outChan = state_reg.bufChan[state_reg.bufHead];

  // signalling level and driver settings
  assign reducedLevel = state_reg.lineFmt[LF_REDUCED_BIT];
  assign driverCurrent = currentFor(state_reg.lineFmt[LF_REDUCED_BIT]);
  assign termSelect = state_reg.drvTerm[DT_TERM_LSB +: 2];
  assign frameClkDrive2x = clockDrive2x(state_reg.drvTerm, state_reg.chanIndex[CI_FCO_BIT]);
  assign bitClkDrive2x = clockDrive2x(state_reg.drvTerm, state_reg.chanIndex[CI_DCO_BIT]);

  // sampling phase, only meaningful with the divider active
  assign samplePhaseCycles = sampleDelay(state_reg.clkPhase, state_reg.clkDiv);

  // bit clock phase, 60 degrees per step
  assign bitClkPhaseStep = state_reg.clkPhase[3:0];
  assign bitClkPhaseDeg = phaseDegrees(bitClkPhaseStep);

  // stream format decode
  logic [2:0] laneMode;
  assign laneMode = state_reg.streamFmt[SF_MODE_LSB +: 3];
  assign serialBitsPerSample = bitsFor(state_reg.streamFmt[SF_BITS_LSB +: 2]);
  assign frame2x = state_reg.streamFmt[SF_FRAME2X_BIT];
  assign {ddrMode, oneLane, byteWise} = laneDecode(laneMode);
  assign lsbFirst = state_reg.streamFmt[SF_LSB_FIRST_BIT];
  assign bitClkMultHalf = multFor(serialBitsPerSample, ddrMode, oneLane);

  // active override limits, rate itself untouched
  assign limitEnable = state_reg.speedActive[6];
  assign limitResolution = state_reg.speedActive[5:4];
  assign limitRate = state_reg.speedActive[2:0];

  // pull-down control
  assign sdioPullDownEn = ~state_reg.userIoB[UB_PULL_OFF_BIT];
endmodule

// ==== tb/aofc_core_properties.sv ====
// assertions on the ports of the output format control block
module aofc_core_properties
  import aofc_pkg::*;
(
  input wire logic clock, // clock
  input wire logic reset_n, // reset
  input wire logic regWrite, // write strobe
  input wire logic regAck, // access done
  input wire logic [9:0] regAddr, // offset
  input wire logic [7:0] regWdata, // write data
  input wire logic [SAMPLE_W-1:0] outData, // word out
  input wire logic outValid, // word offered
  input wire logic outReady, // word taken
  input wire logic sampleReady, // room left
  input wire logic reducedLevel, // level
  input wire logic [1:0] driverCurrent, // current
  input wire logic [1:0] termSelect, // termination
  input wire logic frameClkDrive2x, // frame drive
  input wire logic [3:0] bitClkPhaseStep, // phase code
  input wire logic [9:0] bitClkPhaseDeg, // phase degrees
  input wire logic limitEnable, // override on
  input wire logic sdioPullDownEn // pull-down on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // a write taken by the register port
  sequence s_wr(a);
    regWrite && !regAck && regAddr == a;
  endsequence
  // the acknowledge pulse that follows a write taken while no acknowledge is pending
  sequence s_ack;
    regAck ##1 !regAck;
  endsequence
  a_write_acked: assert property (regWrite && !regAck |=> s_ack)
    else $error("write not acknowledged");
  a_level_select: assert property (s_wr(ADDR_LINE_FMT) |=> reducedLevel == $past(regWdata[6]))
    else $error("level not taken");
  a_current_auto: assert property (driverCurrent == {reducedLevel, 1'b1})
    else $error("current not chosen");
  a_term_select: assert property (s_wr(ADDR_DRV_TERM) |=> termSelect == $past(regWdata[5:4]))
    else $error("termination not taken");
  a_term_wins: assert property (frameClkDrive2x |-> termSelect == 2'h0)
    else $error("2x drive with termination");
  a_phase_degrees: assert property (bitClkPhaseStep <= 4'hB |-> bitClkPhaseDeg == bitClkPhaseStep * 10'h03C)
    else $error("phase degrees wrong");
  a_limit_staged: assert property (s_wr(ADDR_SPEED_LIMIT) |=> $stable(limitEnable))
    else $error("override acted early");
  a_pull_release: assert property (s_wr(ADDR_USER_IO_B) |=> sdioPullDownEn == !$past(regWdata[0]))
    else $error("pull-down wrong");
  a_word_holds: assert property (outValid && !outReady |=> outValid && $stable(outData))
    else $error("word dropped in stall");
  a_full_refuse: assert property (!sampleReady |-> outValid)
    else $error("refusal while empty");
endmodule
bind aofc_core aofc_core_properties aofc_core_properties_i (.clock, .reset_n, .regWrite, .regAck, .regAddr,
  .regWdata, .outData, .outValid, .outReady, .sampleReady, .reducedLevel, .driverCurrent, .termSelect,
  .frameClkDrive2x, .bitClkPhaseStep, .bitClkPhaseDeg, .limitEnable, .sdioPullDownEn);

// ==== tb/aofc_sink_model.sv ====
// receiving logic model: takes formatted words with random stalls
module aofc_sink_model
  import aofc_pkg::*;
(
  input wire logic clock, // clock
  input wire logic reset_n, // reset
  input wire logic [SAMPLE_W-1:0] outData, // word
  input wire logic [1:0] outChan, // channel of word
  input wire logic outValid, // word offered
  input wire logic hold, // stall fully
  output logic outReady // word taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [SAMPLE_W+1:0] got[$]; // channel and word
  initial outReady = 1'b0;
  // ready moves at the falling edge, dropped about one cycle in four
  always @(negedge clock) outReady <= !hold && ($urandom_range(3) != 0);
  // capture every word handed over, with its channel
  always @(posedge clock) if (reset_n && outValid && outReady) got.push_back({outChan, outData});
endmodule

// ==== tb/aofc_core_test.sv ====
// self-checking bench of the output format control block
module aofc_core_test
  import aofc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, sampleValid = 1'b0, hold = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWdata = 8'h00, rdv, d;
  logic [SAMPLE_W-1:0] sampleData = 12'h000, outData;
  logic [1:0] sampleChan = 2'h0, outChan, driverCurrent, termSelect, limitResolution;
  logic regAck, sampleReady, outValid, outReady, reducedLevel, frameClkDrive2x, bitClkDrive2x;
  logic frame2x, ddrMode, oneLane, byteWise, lsbFirst, limitEnable, sdioPullDownEn;
  logic [7:0] regRdata;
  logic [2:0] samplePhaseCycles, limitRate;
  logic [3:0] bitClkPhaseStep, serialBitsPerSample, bitClkMultHalf;
  logic [9:0] bitClkPhaseDeg;
  int err_count = 0, checks_done = 0, cycles = 0, n;
  logic [SAMPLE_W+1:0] expq[$];
  logic [9:0] ra[10] = '{ADDR_CLK_DIV, ADDR_LINE_FMT, ADDR_DRV_TERM, ADDR_CLK_PHASE, ADDR_STREAM_FMT,
    ADDR_SPEED_LIMIT, ADDR_USER_IO_B, ADDR_CHAN_INDEX, ADDR_TRANSFER, 10'h3F0};
  logic [7:0] rv[10] = '{RST_CLK_DIV, RST_LINE_FMT, RST_DRV_TERM, RST_CLK_PHASE, RST_STREAM_FMT,
    RST_SPEED_LIMIT, RST_USER_IO_B, RST_CHAN_INDEX, 8'h00, 8'h00};
  logic [7:0] rm[10] = '{MASK_CLK_DIV, MASK_LINE_FMT, MASK_DRV_TERM, MASK_CLK_PHASE, MASK_STREAM_FMT,
    MASK_SPEED_LIMIT, MASK_USER_IO_B, MASK_CHAN_INDEX, 8'h00, 8'h00};
  logic [7:0] lf[5] = '{8'h00, 8'h04, 8'h41, 8'h05, 8'h01};
  aofc_core aofc_core_i (.clock, .reset_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regAck,
    .sampleData, .sampleChan, .sampleValid, .sampleReady, .outData, .outChan, .outValid, .outReady,
    .reducedLevel, .driverCurrent, .termSelect, .frameClkDrive2x, .bitClkDrive2x, .samplePhaseCycles,
    .bitClkPhaseStep, .bitClkPhaseDeg, .serialBitsPerSample, .frame2x, .ddrMode, .oneLane, .byteWise,
    .lsbFirst, .bitClkMultHalf, .limitResolution, .limitRate, .limitEnable, .sdioPullDownEn);
  aofc_sink_model aofc_sink_model_i (.clock, .reset_n, .outData, .outChan, .outValid, .hold, .outReady);
  // clock and watchdog
  initial forever #2.5 clock = !clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  // compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one register access, strobe held a single cycle
  task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] wd);
    int k;
    k = 0;
    @(negedge clock);
    regWrite = wr;
    regRead = !wr;
    regAddr = a;
    regWdata = wd;
    @(negedge clock);
    regWrite = 1'b0;
    regRead = 1'b0;
    while (regAck !== 1'b1 && k < 4) begin
      @(negedge clock);
      k++;
    end
    rdv = regRdata;
    @(negedge clock);
  endtask
  // expected word: offset binary flips the top bit, invert flips all
  function automatic logic [11:0] fmtw(input logic [7:0] f, input logic [11:0] s);
    return s ^ {!f[0], 11'h000} ^ {12{f[2]}};
  endfunction
  // expected decode of the stream format register
  function automatic logic [15:0] sfx(input logic [7:0] v);
    logic [3:0] b;
    logic one;
    b = (v[1:0] == SF_BITS_10) ? 4'hA : 4'hC;
    one = v[6:4] == SF_MODE_ONE_LANE;
    return {b, v[5] || one, one, v[4], v[7], v[2], 3'h0, (v[5] && !one) ? b >> 1 : b};
  endfunction
  // offer one sample until taken, expectation queued
  task automatic send(input logic [11:0] s, input logic [7:0] f);
    int k;
    k = 0;
    @(negedge clock);
    sampleValid = 1'b1;
    sampleData = s;
    sampleChan = s[1:0];
    #1;
    while (!sampleReady && k < 50) begin
      @(negedge clock);
      #1;
      k++;
    end
    expq.push_back({s[1:0], fmtw(f, s)});
    @(posedge clock);
  endtask
  // wait for the sink, then compare words in order
  task automatic drain();
    for (int k = 0; k < 300 && aofc_sink_model_i.got.size() < expq.size(); k++) @(negedge clock);
    chk(16'(aofc_sink_model_i.got.size()), 16'(expq.size()));
    while (expq.size() > 0 && aofc_sink_model_i.got.size() > 0)
      chk(aofc_sink_model_i.got.pop_front(), expq.pop_front());
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h98F1));
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    foreach (ra[i]) begin
      d = (ra[i] == ADDR_CLK_PHASE) ? 8'h8F : 8'hFF;
      acc(0, ra[i], 8'h00);
      chk(rdv, rv[i]);
      acc(1, ra[i], d);
      acc(0, ra[i], 8'h00);
      chk(rdv, rm[i] & d);
      acc(1, ra[i], rv[i]);
    end
    $display("registers done, %0d mismatches", err_count);
    acc(1, ADDR_DRV_TERM, 8'h01);
    chk({frameClkDrive2x, bitClkDrive2x}, 2'h3);
    acc(1, ADDR_CHAN_INDEX, 8'h1F);
    chk({frameClkDrive2x, bitClkDrive2x}, 2'h2);
    acc(1, ADDR_DRV_TERM, 8'h21);
    chk({termSelect, frameClkDrive2x, bitClkDrive2x}, 4'h8);
    acc(1, ADDR_CLK_DIV, 8'h07);
    for (int c = 0; c < 12; c++) begin
      d = {1'b0, 3'($urandom_range(7)), 4'(c)};
      acc(1, ADDR_CLK_PHASE, d);
      chk(bitClkPhaseDeg, 16'(c) * 16'h003C);
      chk(samplePhaseCycles, d[6:4]);
    end
    for (int c = 0; c < 12; c++) begin
      d = {8'($urandom)} & 8'h87 | {1'b0, 3'($urandom_range(4)), 4'h0};
      acc(1, ADDR_STREAM_FMT, d);
      chk({serialBitsPerSample, ddrMode, oneLane, byteWise, lsbFirst, frame2x, 3'h0, bitClkMultHalf}, sfx(d));
    end
    acc(1, ADDR_SPEED_LIMIT, 8'h55);
    chk(limitEnable, 1'b0);
    acc(1, ADDR_TRANSFER, 8'h01);
    chk({limitEnable, limitResolution, limitRate}, 6'h2D);
    acc(1, ADDR_SPEED_LIMIT, 8'h00);
    acc(1, ADDR_TRANSFER, 8'h00);
    chk(limitEnable, 1'b1);
    for (int v = 0; v < 2; v++) begin
      acc(1, ADDR_USER_IO_B, 8'(v));
      chk(sdioPullDownEn, !v[0]);
    end
    $display("controls done, %0d mismatches", err_count);
    foreach (lf[k]) begin
      acc(1, ADDR_LINE_FMT, lf[k]);
      chk({reducedLevel, driverCurrent}, {lf[k][6], lf[k][6], 1'b1});
      send(12'h800, lf[k]);
      send(12'h7FF, lf[k]);
      repeat (20) send(12'($urandom), lf[k]);
      @(negedge clock);
      sampleValid = 1'b0;
      drain();
    end
    hold = 1'b1;
    repeat (2) @(negedge clock);
    n = 0;
    sampleValid = 1'b1;
    repeat (4) begin
      sampleData = 12'($urandom);
      #1;
      if (sampleReady) expq.push_back({sampleChan, fmtw(8'h01, sampleData)});
      n += int'(sampleReady);
      @(negedge clock);
    end
    sampleValid = 1'b0;
    chk(16'(n), 16'h0002);
    chk({sampleReady, outValid}, 2'h1);
    hold = 1'b0;
    drain();
    chk(outValid, 1'b0);
    $display("stream done, %0d mismatches", err_count);
    stop_test();
  end
endmodule
